/* psu_supervisor_pkg.sv */
// constants, register map and field layout of the protection supervisor
package psu_supervisor_pkg;
    // register indices on the plain register port
    localparam logic [3:0] ADDR_PROT_CFG   = 4'h0;
    localparam logic [3:0] ADDR_OPP_CFG    = 4'h1;
    localparam logic [3:0] ADDR_OPP_TIMERS = 4'h2;
    localparam logic [3:0] ADDR_RESTART    = 4'h3;
    localparam logic [3:0] ADDR_BOOST_CFG  = 4'h4;
    localparam logic [3:0] ADDR_NV_LOCK    = 4'h5;
    localparam logic [3:0] ADDR_STATUS     = 4'h6;
    localparam logic [3:0] ADDR_PROT_REC   = 4'h7;
    localparam logic [3:0] ADDR_NV_DATA    = 4'h8;
    localparam logic [3:0] ADDR_NV_CMD     = 4'h9;

    // protection policy encodings
    localparam logic [1:0] POL_LATCHED      = 2'h0;
    localparam logic [1:0] POL_SAFE_RESTART = 2'h1;
    localparam logic [1:0] POL_LATCH_AFTER  = 2'h2;

    // nonvolatile store command codes
    localparam logic [1:0] NV_CMD_DEFAULTS = 2'h1;
    localparam logic [1:0] NV_CMD_WRITE    = 2'h2;

    // protection record bit positions
    localparam int REC_OPP1 = 0;
    localparam int REC_OPP2 = 1;
    localparam int REC_OVP  = 2;
    localparam int REC_OCP  = 3;
    localparam int REC_UVP  = 4;
    localparam int REC_OTP  = 5;
    localparam int REC_W    = 6;

    // reset values
    localparam logic [15:0] RST_PROT_CFG  = 16'h0003;
    localparam logic [15:0] RST_OPP_CFG   = 16'h3214;
    localparam logic [15:0] RST_BOOST_CFG = 16'h0000;
    localparam logic [7:0]  RST_RETRY_MAX = 8'h03;

    // timing: 40 MHz clock, tick of 1 ms for slow counters
    localparam int CLK_HZ          = 40_000_000;
    localparam int TICK_US         = 1000;
    localparam int TICK_CYC        = CLK_HZ / 1_000_000 * TICK_US;
    localparam int RETRY_CLEAR_MS  = 5000;
    localparam int FB_RAMP_STEPS   = 16;
    localparam int FB_RAMP_CYC     = 4;
    localparam logic [7:0] OPP_NEAR_MARGIN = 8'h04;
endpackage

/* psu_protection_supervisor.sv */
// protection policy, power-good ramp and settings registers of the supervisor
`timescale 1ns/100ps
module psu_protection_supervisor #(
    parameter int RETRY_CLEAR_TICKS = psu_supervisor_pkg::RETRY_CLEAR_MS,
    parameter int TICK_CYCLES       = psu_supervisor_pkg::TICK_CYC
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [15:0] rdata,
    input  wire logic [7:0]  power_pct,
    input  wire logic        boost_below_pg,
    input  wire logic        otp_imminent,
    input  wire logic        brownout_stop_imminent,
    input  wire logic        mains_below_brownout,
    input  wire logic        supply_uvp,
    input  wire logic        fault_ovp,
    input  wire logic        fault_ocp,
    input  wire logic        fault_uvp,
    input  wire logic        nv_load_done,
    output logic             power_limit,
    output logic             switching_enable,
    output logic      [3:0]  feedback_sense_level,
    output logic             supply_start_high,
    output logic      [1:0]  boost_soft_start_sel,
    output logic      [1:0]  xcap_delay_sel,
    output logic      [1:0]  boost_burst_hyst_sel,
    output logic             boost_burst_sync,
    output logic      [1:0]  boost_burst_ss_sel,
    output logic      [1:0]  boost_burst_sp_sel
);
    initial begin
        if (TICK_CYCLES < 1 || RETRY_CLEAR_TICKS < 1 ||
            RETRY_CLEAR_TICKS > 65535) begin
            $error("tick or retry clear count out of range");
        end
    end

    typedef enum logic [1:0] {ST_LOAD, ST_RUN, ST_WAIT, ST_LATCH} state_e;

    // default timer settings, in ticks, and the overpower level arithmetic
    localparam logic [15:0] OPP_TIMERS_RST = 16'h1010;
    localparam logic [15:0] RESTART_RST    = 16'h0a0a;
    localparam logic [7:0]  MAX_PCT_BASE   = 8'h64;
    localparam logic [7:0]  LVL1_STEP      = 8'h05;
    localparam logic [7:0]  LVL2_STEP      = 8'h0a;
    localparam int          REC_WIDTH      = psu_supervisor_pkg::REC_W;

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [15:0]  prot_cfg_ff;    // policy, retry max, start level
    logic [15:0]  opp_cfg_ff;     // max pct, offsets
    logic [15:0]  opp_timers_ff;  // level1, level2 timer in ticks
    logic [15:0]  restart_ff;     // restart wait, brownout reset time
    logic [15:0]  boost_cfg_ff;
    logic [1:0]   lock_ff;        // bit0 read lock, bit1 write lock
    logic [15:0]  nv_data_ff;
    logic [REC_WIDTH-1:0] rec_ff;
    state_e       state_ff;
    logic [7:0]   retry_ff;
    logic [15:0]  quiet_ff;
    logic [7:0]   opp1_ff;
    logic [7:0]   opp2_ff;
    logic [7:0]   wait_ff;
    logic [7:0]   bo_ff;
    logic [15:0]  tick_cnt_ff;
    logic         tick_ff;
    logic [1:0]   ramp_div_ff;
    logic [3:0]   fb_ff;

    ////////////////////////////////////////////////////////////////////////
    // decode
    function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
        hit = (a == r);
    endfunction

    wire [1:0] policy     = prot_cfg_ff[1:0];
    wire [7:0] retry_max  = prot_cfg_ff[15:8];
    wire       opp1_en    = opp_cfg_ff[14];
    wire       opp2_en    = opp_cfg_ff[15];
    wire [7:0] max_pct    = {1'b0, opp_cfg_ff[6:0]} + MAX_PCT_BASE;
    wire [7:0] lvl1       = max_pct - {4'h0, opp_cfg_ff[10:7]} * LVL1_STEP;
    wire [7:0] lvl2       = max_pct - {5'h00, opp_cfg_ff[13:11]} * LVL2_STEP;
    wire       wr_nv_cmd  = wr_en && hit(addr, psu_supervisor_pkg::ADDR_NV_CMD);
    wire       nv_default = wr_nv_cmd &&
                            wdata[1:0] == psu_supervisor_pkg::NV_CMD_DEFAULTS;
    wire       nv_write   = wr_nv_cmd && !lock_ff[1] &&
                            wdata[1:0] == psu_supervisor_pkg::NV_CMD_WRITE;
    wire       over1      = opp1_en && power_pct > lvl1;
    wire       over2      = opp2_en && power_pct > lvl2;
    wire       opp1_trip  = over1 && opp1_ff >= opp_timers_ff[7:0];
    wire       opp2_trip  = over2 && opp2_ff >= opp_timers_ff[15:8];
    wire       hard_fault = fault_ovp || fault_ocp || fault_uvp;
    wire       running    = state_ff == ST_RUN;
    wire       trigger    = running && (opp1_trip || opp2_trip || hard_fault);
    wire       bo_reset   = mains_below_brownout &&
                            bo_ff >= restart_ff[15:8];
    wire       latch_now  = policy == psu_supervisor_pkg::POL_LATCHED ||
                            (policy == psu_supervisor_pkg::POL_LATCH_AFTER &&
                             retry_ff + 8'h01 >= retry_max);
    wire       opp_near   = (over1 && opp1_ff + psu_supervisor_pkg::
                             OPP_NEAR_MARGIN >= opp_timers_ff[7:0]) ||
                            (over2 && opp2_ff + psu_supervisor_pkg::
                             OPP_NEAR_MARGIN >= opp_timers_ff[15:8]);
    wire       fb_high    = !running || boost_below_pg || opp_near ||
                            otp_imminent || brownout_stop_imminent;
    wire [REC_WIDTH-1:0] rec_set = trigger ? {otp_imminent & 1'b0,
                            fault_uvp, fault_ocp, fault_ovp,
                            opp2_trip, opp1_trip} : '0;

    ////////////////////////////////////////////////////////////////////////
    // state machine
    state_e nxt_state;
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_LOAD:  if (nv_load_done) nxt_state = ST_RUN;
            ST_RUN:   if (trigger)
                          nxt_state = latch_now ? ST_LATCH : ST_WAIT;
            ST_WAIT:  if (tick_ff && wait_ff >= restart_ff[7:0])
                          nxt_state = ST_RUN;
            ST_LATCH: if (supply_uvp) nxt_state = ST_LOAD;
            default:  nxt_state = ST_LOAD;
        endcase
        if (bo_reset && state_ff != ST_LOAD) nxt_state = ST_RUN;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff    <= ST_LOAD;
            tick_cnt_ff <= 16'h0000;
            tick_ff     <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            tick_ff     <= tick_cnt_ff == 16'(TICK_CYCLES - 1);
            tick_cnt_ff <= tick_cnt_ff == 16'(TICK_CYCLES - 1) ? 16'h0000
                           : tick_cnt_ff + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // timers and retry counter
    always_ff @(posedge clk) begin
        if (reset) begin
            opp1_ff  <= 8'h00;
            opp2_ff  <= 8'h00;
            wait_ff  <= 8'h00;
            bo_ff    <= 8'h00;
            retry_ff <= 8'h00;
            quiet_ff <= 16'h0000;
        end else begin
            if (!over1 || !running) opp1_ff <= 8'h00;
            else if (tick_ff && opp1_ff != 8'hff) opp1_ff <= opp1_ff + 8'h01;
            if (!over2 || !running) opp2_ff <= 8'h00;
            else if (tick_ff && opp2_ff != 8'hff) opp2_ff <= opp2_ff + 8'h01;
            if (state_ff != ST_WAIT) wait_ff <= 8'h00;
            else if (tick_ff) wait_ff <= wait_ff + 8'h01;
            if (!mains_below_brownout) bo_ff <= 8'h00;
            else if (tick_ff && bo_ff != 8'hff) bo_ff <= bo_ff + 8'h01;
            if (trigger) begin
                quiet_ff <= 16'h0000;
                if (policy == psu_supervisor_pkg::POL_LATCH_AFTER)
                    retry_ff <= retry_ff + 8'h01;
            end else if (quiet_ff >= 16'(RETRY_CLEAR_TICKS)) begin
                retry_ff <= 8'h00;
            end else if (tick_ff) begin
                quiet_ff <= quiet_ff + 16'h0001;
            end
            if (bo_reset) retry_ff <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register writes and record
    always_ff @(posedge clk) begin
        if (reset) begin
            prot_cfg_ff   <= psu_supervisor_pkg::RST_PROT_CFG;
            opp_cfg_ff    <= psu_supervisor_pkg::RST_OPP_CFG;
            opp_timers_ff <= OPP_TIMERS_RST;
            restart_ff    <= RESTART_RST;
            boost_cfg_ff  <= psu_supervisor_pkg::RST_BOOST_CFG;
            lock_ff       <= 2'b00;
            nv_data_ff    <= 16'h0000;
            rec_ff        <= '0;
        end else begin
            if (wr_en && hit(addr, psu_supervisor_pkg::ADDR_PROT_CFG))
                prot_cfg_ff <= wdata;
            if (wr_en && hit(addr, psu_supervisor_pkg::ADDR_OPP_CFG))
                opp_cfg_ff <= wdata;
            if (wr_en && hit(addr, psu_supervisor_pkg::ADDR_OPP_TIMERS))
                opp_timers_ff <= wdata;
            if (wr_en && hit(addr, psu_supervisor_pkg::ADDR_RESTART))
                restart_ff <= wdata;
            if (wr_en && hit(addr, psu_supervisor_pkg::ADDR_BOOST_CFG))
                boost_cfg_ff <= wdata;
            if (wr_en && hit(addr, psu_supervisor_pkg::ADDR_NV_LOCK))
                lock_ff <= lock_ff | wdata[1:0];
            if (nv_write) nv_data_ff <= wdata;
            if (nv_default) begin
                lock_ff    <= 2'b00;
                nv_data_ff <= 16'h0000;
            end
            // set wins over a software clear in the same cycle
            if (wr_en && hit(addr, psu_supervisor_pkg::ADDR_PROT_REC))
                rec_ff <= (rec_ff & ~wdata[REC_WIDTH-1:0]) | rec_set;
            else
                rec_ff <= rec_ff | rec_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port, power-good ramp and outputs
    wire [15:0] status_word = {6'h00, retry_ff, 2'(state_ff)};
    wire [15:0] rd_mux =
        hit(addr, psu_supervisor_pkg::ADDR_PROT_CFG)   ? prot_cfg_ff :
        hit(addr, psu_supervisor_pkg::ADDR_OPP_CFG)    ? opp_cfg_ff :
        hit(addr, psu_supervisor_pkg::ADDR_OPP_TIMERS) ? opp_timers_ff :
        hit(addr, psu_supervisor_pkg::ADDR_RESTART)    ? restart_ff :
        hit(addr, psu_supervisor_pkg::ADDR_BOOST_CFG)  ? boost_cfg_ff :
        hit(addr, psu_supervisor_pkg::ADDR_NV_LOCK)    ? {14'h0000, lock_ff} :
        hit(addr, psu_supervisor_pkg::ADDR_STATUS)     ? status_word :
        hit(addr, psu_supervisor_pkg::ADDR_PROT_REC)   ?
            {{(16-REC_WIDTH){1'b0}}, rec_ff} :
        (hit(addr, psu_supervisor_pkg::ADDR_NV_DATA) && !lock_ff[0]) ?
            nv_data_ff : 16'h0000;

    wire        ramp_step = ramp_div_ff == 2'(psu_supervisor_pkg::FB_RAMP_CYC-1);
    wire        stop_now  = hard_fault || !running || nxt_state != ST_RUN;

    always_ff @(posedge clk) begin
        if (reset) begin
            rdata            <= 16'h0000;
            ramp_div_ff      <= 2'b00;
            fb_ff            <= 4'hf;
            feedback_sense_level <= 4'hf;
            power_limit      <= 1'b0;
            switching_enable <= 1'b0;
            supply_start_high    <= 1'b1;
            boost_soft_start_sel <= 2'b00;
            xcap_delay_sel       <= 2'b00;
            boost_burst_hyst_sel <= 2'b00;
            boost_burst_sync     <= 1'b0;
            boost_burst_ss_sel   <= 2'b00;
            boost_burst_sp_sel   <= 2'b00;
        end else begin
            rdata       <= rd_en ? rd_mux : 16'h0000;
            ramp_div_ff <= ramp_div_ff + 2'b01;
            if (hard_fault) fb_ff <= 4'hf;
            else if (ramp_step && fb_high && fb_ff != 4'hf)
                fb_ff <= fb_ff + 4'h1;
            else if (ramp_step && !fb_high && fb_ff != 4'h0)
                fb_ff <= fb_ff - 4'h1;
            feedback_sense_level <= hard_fault ? 4'hf : fb_ff;
            power_limit      <= running && power_pct > max_pct;
            switching_enable <= !stop_now;
            supply_start_high    <= prot_cfg_ff[2];
            boost_soft_start_sel <= boost_cfg_ff[1:0];
            xcap_delay_sel       <= boost_cfg_ff[3:2];
            boost_burst_hyst_sel <= boost_cfg_ff[5:4];
            boost_burst_sync     <= boost_cfg_ff[6];
            boost_burst_ss_sel   <= boost_cfg_ff[9:8];
            boost_burst_sp_sel   <= boost_cfg_ff[11:10];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_hard_fault_stop: assert property (@(posedge clk) disable iff (reset)
        hard_fault |=> !switching_enable && feedback_sense_level == 4'hf)
        else $error("hard fault did not stop switching");
    a_load_before_run: assert property (@(posedge clk) disable iff (reset)
        state_ff == ST_LOAD |=> !switching_enable)
        else $error("switching before settings loaded");
    a_latch_holds: assert property (@(posedge clk) disable iff (reset)
        state_ff == ST_LATCH && !supply_uvp && !bo_reset
        |=> state_ff == ST_LATCH)
        else $error("latched stop left without reset cause");
    a_record_sticky: assert property (@(posedge clk) disable iff (reset)
        rec_ff[psu_supervisor_pkg::REC_OVP] && !(wr_en && addr ==
        psu_supervisor_pkg::ADDR_PROT_REC)
        |=> rec_ff[psu_supervisor_pkg::REC_OVP])
        else $error("protection record lost");
    a_read_lock: assert property (@(posedge clk) disable iff (reset)
        rd_en && addr == psu_supervisor_pkg::ADDR_NV_DATA && lock_ff[0]
        |=> rdata == 16'h0000)
        else $error("locked store was read");
    a_write_lock: assert property (@(posedge clk) disable iff (reset)
        lock_ff[1] && !nv_default |=> $stable(nv_data_ff))
        else $error("locked store was written");
    a_ramp_step: assert property (@(posedge clk) disable iff (reset)
        !$past(hard_fault) |-> (fb_ff - $past(fb_ff) <= 4'h1 ||
        $past(fb_ff) - fb_ff <= 4'h1))
        else $error("feedback level stepped");
    a_power_limit: assert property (@(posedge clk) disable iff (reset)
        running && power_pct > max_pct && nxt_state == ST_RUN
        |=> power_limit)
        else $error("power not limited above maximum");
    a_opp1_trip_stop: assert property (@(posedge clk) disable iff (reset)
        running && opp1_trip |=> !switching_enable)
        else $error("first overpower timer did not stop switching");
    a_opp2_trip_stop: assert property (@(posedge clk) disable iff (reset)
        running && opp2_trip |=> !switching_enable)
        else $error("second overpower timer did not stop switching");
    a_restart_wait: assert property (@(posedge clk) disable iff (reset)
        state_ff == ST_WAIT && !bo_reset &&
        !(tick_ff && wait_ff >= restart_ff[7:0]) |=> state_ff == ST_WAIT)
        else $error("safe restart left before its period");
    a_retry_latch: assert property (@(posedge clk) disable iff (reset)
        trigger && !bo_reset &&
        policy == psu_supervisor_pkg::POL_LATCH_AFTER &&
        retry_ff + 8'h01 >= retry_max |=> state_ff == ST_LATCH)
        else $error("retry count reached without latching");
    a_retry_clear: assert property (@(posedge clk) disable iff (reset)
        !trigger && quiet_ff >= 16'(RETRY_CLEAR_TICKS) |=> retry_ff == 8'h00)
        else $error("retry counter kept after quiet period");
    a_brownout_exit: assert property (@(posedge clk) disable iff (reset)
        bo_reset && state_ff != ST_LOAD |=> state_ff == ST_RUN)
        else $error("brownout reset did not restart");
    a_fb_start_high: assert property (@(posedge clk) disable iff (reset)
        !running && fb_ff == 4'hf |=> fb_ff == 4'hf)
        else $error("feedback sense left high level outside operation");
    a_nv_defaults: assert property (@(posedge clk) disable iff (reset)
        nv_default |=> lock_ff == 2'b00)
        else $error("defaults restore kept a lock");
    // the copies below are plain registers; the check pins their one-cycle lag
    a_start_level: assert property (@(posedge clk) disable iff (reset)
        1'b1 |=> supply_start_high == $past(prot_cfg_ff[2]))
        else $error("start level not taken from settings");
    a_soft_start: assert property (@(posedge clk) disable iff (reset)
        1'b1 |=> boost_soft_start_sel == $past(boost_cfg_ff[1:0]))
        else $error("soft start select not taken from settings");
    a_xcap_delay: assert property (@(posedge clk) disable iff (reset)
        1'b1 |=> xcap_delay_sel == $past(boost_cfg_ff[3:2]))
        else $error("discharge delay not taken from settings");
    a_burst_hyst: assert property (@(posedge clk) disable iff (reset)
        1'b1 |=> boost_burst_hyst_sel == $past(boost_cfg_ff[5:4]))
        else $error("burst hysteresis not taken from settings");
    a_burst_sync: assert property (@(posedge clk) disable iff (reset)
        1'b1 |=> boost_burst_sync == $past(boost_cfg_ff[6]))
        else $error("burst sync not taken from settings");
    a_burst_soft: assert property (@(posedge clk) disable iff (reset)
        1'b1 |=> boost_burst_ss_sel == $past(boost_cfg_ff[9:8]) &&
        boost_burst_sp_sel == $past(boost_cfg_ff[11:10]))
        else $error("burst soft start or stop not taken from settings");
endmodule // psu_protection_supervisor

/* power_stage_model.sv */
// behavioural power stage: delivered power follows the load while switching
`timescale 1ns/100ps
module power_stage_model (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       switching_enable,
    input  wire logic [7:0] load_pct,
    output logic      [7:0] power_pct
);
    ////////////////////////////////////////////////////////////////////////
    // a stopped stage delivers nothing, so a trip cannot feed itself
    always_ff @(posedge clk) begin
        if (reset || !switching_enable) begin
            power_pct <= 8'h00;
        end else begin
            power_pct <= load_pct;
        end
    end
endmodule // power_stage_model

/* psu_protection_supervisor_test.sv */
// self-checking bench of the protection supervisor with a power stage model
`timescale 1ns/100ps
module psu_protection_supervisor_test;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic [7:0]  load_pct = 8'h00;
    logic [2:0]  pg_v = 3'h0;
    logic [2:0]  fault_v = 3'h0;
    logic        mains_low = 1'b0;
    logic        supply_uvp = 1'b0;
    logic        nv_load_done = 1'b0;
    logic [15:0] rdata, rd_val, bv;
    logic [7:0]  power_pct;
    logic        power_limit, sw_en, start_hi, sync;
    logic [3:0]  fb;
    logic [1:0]  k, ss, xc, hy, bss, bsp;
    int          n_fail = 0;
    int          checks = 0;

    always #12.5 clk = ~clk;

    psu_protection_supervisor #(.RETRY_CLEAR_TICKS(20), .TICK_CYCLES(4))
    i_psu_protection_supervisor (
        .clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .power_pct(power_pct),
        .boost_below_pg(pg_v[0]), .otp_imminent(pg_v[1]),
        .brownout_stop_imminent(pg_v[2]), .mains_below_brownout(mains_low),
        .supply_uvp(supply_uvp), .fault_ovp(fault_v[0]),
        .fault_ocp(fault_v[1]), .fault_uvp(fault_v[2]),
        .nv_load_done(nv_load_done), .power_limit(power_limit),
        .switching_enable(sw_en), .feedback_sense_level(fb),
        .supply_start_high(start_hi), .boost_soft_start_sel(ss),
        .xcap_delay_sel(xc), .boost_burst_hyst_sel(hy),
        .boost_burst_sync(sync), .boost_burst_ss_sel(bss),
        .boost_burst_sp_sel(bsp));

    power_stage_model i_power_stage_model (
        .clk(clk), .reset(reset), .switching_enable(sw_en),
        .load_pct(load_pct), .power_pct(power_pct));

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("n_fail=%0d checks=%0d", n_fail, checks);
        if (n_fail == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got,
                     exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 rd_val = rdata;
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [15:0] exp,
                         input string what);
        rd(a);
        chk(rd_val, exp, what);
    endtask

    task automatic wait_sw(input logic v, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            #1;
            if (sw_en === v) break;
        end
        chk({15'h0000, sw_en}, {15'h0000, v}, "switching wait");
        if (sw_en !== v) stop_test();
    endtask

    // the level may only move one step per cycle while it ramps
    task automatic wait_fb(input logic [3:0] lvl, input int n);
        int d;
        logic [3:0] prev;
        prev = fb;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            #1;
            d = int'(fb) - int'(prev);
            if (d > 1 || d < -1) chk({12'h000, fb}, {12'h000, prev}, "step");
            prev = fb;
            if (fb === lvl) break;
        end
        chk({12'h000, fb}, {12'h000, lvl}, "feedback wait");
        if (fb !== lvl) stop_test();
    endtask

    // trips one protection under the latched policy, then releases it
    task automatic trip(input logic [15:0] cfg, input logic [7:0] ld,
                        input logic [2:0] flt, input int bn, input logic uv);
        wr(psu_supervisor_pkg::ADDR_OPP_CFG, cfg);
        load_pct <= ld;
        fault_v <= flt;
        if (flt != 3'h0) begin
            repeat (2) @(posedge clk);
            #1 chk({11'h000, sw_en, fb}, 16'h000F, "fault stop");
            fault_v <= 3'h0;
        end
        wait_sw(1'b0, 200);
        repeat (100) @(posedge clk);
        load_pct <= 8'h32;
        #1 chk({15'h0000, sw_en}, 16'h0000, "latched");
        rdchk(psu_supervisor_pkg::ADDR_PROT_REC, 16'h0001 << bn, "rec");
        supply_uvp <= uv;
        mains_low <= !uv;
        repeat (uv ? 1 : 40) @(posedge clk);
        supply_uvp <= 1'b0;
        mains_low <= 1'b0;
        wait_sw(1'b1, 200);
        rdchk(psu_supervisor_pkg::ADDR_PROT_REC, 16'h0001 << bn, "kept");
        wr(psu_supervisor_pkg::ADDR_PROT_REC, 16'hFFFF);
        rdchk(psu_supervisor_pkg::ADDR_PROT_REC, 16'h0000, "clear");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        #1 chk({sw_en, start_hi, fb, 10'h000}, 16'h7C00, "reset");
        rdchk(psu_supervisor_pkg::ADDR_OPP_CFG,
              psu_supervisor_pkg::RST_OPP_CFG, "opp cfg reset");
        repeat (20) @(posedge clk);
        #1 chk({15'h0000, sw_en}, 16'h0000, "no load yet");
        nv_load_done <= 1'b1;
        wait_sw(1'b1, 200);
        wait_fb(4'h0, 200);
        rdchk(4'hF, 16'h0000, "unmapped");
        wr(psu_supervisor_pkg::ADDR_PROT_CFG, 16'h0200);
        repeat (2) @(posedge clk);
        #1 chk({15'h0000, start_hi}, 16'h0000, "12 V start");
        wr(psu_supervisor_pkg::ADDR_PROT_CFG, 16'h0204);
        repeat (2) @(posedge clk);
        #1 chk({15'h0000, start_hi}, 16'h0001, "19 V start");
        wr(psu_supervisor_pkg::ADDR_OPP_TIMERS, 16'h0202);
        wr(psu_supervisor_pkg::ADDR_RESTART, 16'h0203);
        for (int j = 0; j < 4; j++) begin
            k = j[1:0];
            bv = {4'h0, k, k, 1'b0, k[0], k, k, k};
            wr(psu_supervisor_pkg::ADDR_BOOST_CFG, bv);
            repeat (2) @(posedge clk);
            #1 chk({4'h0, bsp, bss, 1'b0, sync, hy, xc, ss}, bv, "boost");
        end
        load_pct <= 8'h78;
        repeat (8) @(posedge clk);
        #1 chk({14'h0000, power_limit, sw_en}, 16'h0001, "at max");
        load_pct <= 8'h79;
        repeat (8) @(posedge clk);
        #1 chk({14'h0000, power_limit, sw_en}, 16'h0003, "above max");
        load_pct <= 8'h32;
        for (int j = 0; j < 3; j++) begin
            pg_v <= 3'h1 << j;
            wait_fb(4'hF, 200);
            chk({15'h0000, sw_en}, 16'h0001, "still running");
            pg_v <= 3'h0;
            wait_fb(4'h0, 200);
        end
        trip(16'h7214, 8'h6E, 3'h0, psu_supervisor_pkg::REC_OPP1, 1'b0);
        trip(16'hB214, 8'h5A, 3'h0, psu_supervisor_pkg::REC_OPP2, 1'b1);
        trip(16'h3214, 8'h32, 3'h1, psu_supervisor_pkg::REC_OVP, 1'b0);
        trip(16'h3214, 8'h32, 3'h2, psu_supervisor_pkg::REC_OCP, 1'b1);
        trip(16'h3214, 8'h32, 3'h4, psu_supervisor_pkg::REC_UVP, 1'b0);
        wr(psu_supervisor_pkg::ADDR_PROT_CFG, 16'h0205);
        wr(psu_supervisor_pkg::ADDR_OPP_CFG, 16'h7214);
        load_pct <= 8'h6E;
        for (int j = 0; j < 2; j++) begin
            wait_sw(1'b0, 200);
            repeat (6) @(posedge clk);
            #1 chk({15'h0000, sw_en}, 16'h0000, "restart wait");
            wait_sw(1'b1, 200);
        end
        load_pct <= 8'h32;
        repeat (100) @(posedge clk);
        wait_sw(1'b1, 200);
        wr(psu_supervisor_pkg::ADDR_PROT_CFG, 16'h0206);
        load_pct <= 8'h6E;
        wait_sw(1'b0, 200);
        load_pct <= 8'h32;
        wait_sw(1'b1, 200);
        rd(psu_supervisor_pkg::ADDR_STATUS);
        chk({8'h00, rd_val[9:2]}, 16'h0001, "retry one");
        repeat (150) @(posedge clk);
        rd(psu_supervisor_pkg::ADDR_STATUS);
        chk({8'h00, rd_val[9:2]}, 16'h0000, "retry cleared");
        load_pct <= 8'h6E;
        wait_sw(1'b0, 200);
        wait_sw(1'b1, 200);
        wait_sw(1'b0, 200);
        repeat (100) @(posedge clk);
        #1 chk({15'h0000, sw_en}, 16'h0000, "latched after");
        wr(psu_supervisor_pkg::ADDR_NV_CMD, 16'h1232);
        rdchk(psu_supervisor_pkg::ADDR_NV_DATA, 16'h1232, "nv write");
        wr(psu_supervisor_pkg::ADDR_NV_LOCK, 16'h0002);
        wr(psu_supervisor_pkg::ADDR_NV_CMD, 16'h5672);
        rdchk(psu_supervisor_pkg::ADDR_NV_DATA, 16'h1232, "wr lock");
        wr(psu_supervisor_pkg::ADDR_NV_LOCK, 16'h0001);
        rdchk(psu_supervisor_pkg::ADDR_NV_DATA, 16'h0000, "rd lock");
        rdchk(psu_supervisor_pkg::ADDR_NV_LOCK, 16'h0003, "locks");
        wr(psu_supervisor_pkg::ADDR_NV_CMD, 16'h0001);
        rdchk(psu_supervisor_pkg::ADDR_NV_LOCK, 16'h0000, "unlock");
        stop_test();
    end
endmodule // psu_protection_supervisor_test
